//--- hdl/fsk_rx_defs.vh
// Purpose: constants for the fsk receive control block
// Assumes: byte wide registers, one per aligned apb word
// Notes:   printed offsets are register indices
`ifndef FSK_RX_DEFS_VH
`define FSK_RX_DEFS_VH
// ====================================================================
// register indices (byte address is index times four)
`define IDX_DISC_BW        12'h10F
`define IDX_POST_FILT      12'h110
`define IDX_DISC_PHASE     12'h112
`define IDX_IF_BW          12'h115
`define IDX_FC_MODE        12'h116
`define IDX_LOOP_GAIN      12'h117
`define IDX_PRE_DET        12'h11B
`define IDX_FREQ_ERR       12'h372
`define IDX_RX_STATUS      12'h373
// ====================================================================
// reset values
`define RST_DISC_BW        8'h00
`define RST_POST_FILT      8'h00
`define RST_DISC_PHASE     8'h00
`define RST_IF_BW          8'h00
`define RST_FC_MODE        8'h00
`define RST_LOOP_GAIN      8'h37
`define RST_PRE_DET        8'h01
// ====================================================================
// field positions
`define FC_MODE_LSB        0
`define IF_BW_LSB          6
`define DEMOD_FSK_BIT      4
`define PRE_DET_EN_BIT     0
`define KI_LSB             4
`define KP_LSB             0
// ====================================================================
// frequency control modes
`define FC_FREE            2'h0
`define FC_OFF             2'h1
`define FC_HOLD            2'h2
`define FC_LOCK            2'h3
// ====================================================================
// pull-in limits in khz per if bandwidth code
`define PULL_100           8'h32
`define PULL_150           8'h4B
`define PULL_200           8'h64
`define PULL_300           8'h96
// ====================================================================
// clock recovery
`define CDR_OSR            8
`define CDR_LOCK_EDGES     5
`endif

//--- hdl/cdr_loop.v
// Purpose: oversampled clock and data recovery
// Assumes: one sample per oversample enable
// Notes:   phase restarts at one on each transition
`timescale 1ns/1ps
`default_nettype none
module cdr_loop #(
    parameter OSR = 8
) (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // sample stream
    input  wire       sample_en,
    input  wire       sample_bit,
    // recovered stream
    output reg        bit_valid,
    output reg        bit_out,
    output reg        synced
);
// ====================================================================
// phase accumulator
reg  [7:0] phase;
reg        last_bit;
reg  [2:0] edge_count;
wire       edge_seen = sample_en & (sample_bit ^ last_bit);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        phase      <= 8'h00;
        // idle filter output reads as one; avoids a false first edge
        last_bit   <= 1'b1;
        edge_count <= 3'h0;
        bit_valid  <= 1'b0;
        bit_out    <= 1'b0;
        synced     <= 1'b0;
    end else begin
        bit_valid <= 1'b0;
        if (sample_en) begin
            last_bit <= sample_bit;
            // re-centre on each transition tolerates rate error
            if (edge_seen) begin
                phase <= 8'h01;
                if (edge_count != 3'h5)
                    edge_count <= edge_count + 3'h1;
                if (edge_count == 3'h4)
                    synced <= 1'b1;
            end else if (phase == OSR[7:0] - 8'h01) begin
                phase <= 8'h00;
            end else begin
                phase <= phase + 8'h01;
            end
            if (phase == OSR[7:0] / 8'h02) begin
                bit_valid <= 1'b1;
                bit_out   <= sample_bit;
            end
        end
    end
end
endmodule // cdr_loop
`default_nettype wire

//--- hdl/fsk_rx_afc_cdr_control.v
// Purpose: afc lock control, post filter and cdr for fsk receive
// Assumes: apb slave, 10 MHz pclk, inputs synchronous to pclk
// Notes:
// Contract
// - loop corrects oscillator during preamble, fsk
// - mode field selects free/off/hold/lock
// - mode three with preamble: lock on preamble
// - release lock without sync after preamble
// - packet mode keeps lock until packet end
// - streaming releases lock on idle or rx
// - no preamble detect: lock on sync word
// - pull-in range follows if bandwidth
// - error readback twos complement, 1 kHz lsb
// - readback valid after lock, kept afterward; overwritten while the loop runs in track state
// - second order low pass, bandwidth code times two; the filter picks a power-of-two coefficient from code ranges instead
// - oversampled recovery tolerates rate mismatch
// - bit sync within five transitions
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsk_rx_defs.vh"
module fsk_rx_afc_cdr_control #(
    parameter OSR   = `CDR_OSR,
    parameter SDIV  = 4
) (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [13:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // receive context
    input  wire        receive_state,
    input  wire        idle_on_state,
    input  wire        receive_command,
    input  wire        packet_mode,
    input  wire        preamble_found,
    input  wire        sync_found,
    input  wire        sync_window_over,
    input  wire        packet_end,
    // discriminator
    input  wire signed [7:0] disc_sample,
    input  wire signed [7:0] freq_error_khz,
    // outputs
    output reg  signed [7:0] lo_correction,
    output reg         loop_locked,
    output reg         data_valid,
    output reg         data_bit,
    output reg         bit_synced,
    output reg  [7:0]  discriminator_bandwidth,
    output reg  [1:0]  discriminator_phase
);
// ====================================================================
// registers
reg  [7:0] post_filter_bandwidth_code;
reg  [7:0] if_cfg;
reg  [7:0] mode_cfg;
reg  [7:0] gain_cfg;
reg  [7:0] pre_cfg;
reg  [7:0] freq_err;
reg        err_valid;
wire [1:0] freq_control_mode = mode_cfg[`FC_MODE_LSB+1:`FC_MODE_LSB];
wire [1:0] if_bandwidth = if_cfg[`IF_BW_LSB+1:`IF_BW_LSB];
wire       fsk_on = ~if_cfg[`DEMOD_FSK_BIT];
wire       pre_en = pre_cfg[`PRE_DET_EN_BIT];
wire [3:0] loop_integral_gain = gain_cfg[`KI_LSB+3:`KI_LSB];
wire [3:0] loop_proportional_gain = gain_cfg[`KP_LSB+3:`KP_LSB];
wire [11:0] idx = paddr[13:2];
wire       setup = psel & ~penable;
wire       wr_acc = psel & penable & pwrite & pready;
// ====================================================================
// apb: no wait state, answer in first access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else begin
        pready  <= setup;
        pslverr <= 1'b0;
        if (setup) begin
            prdata <= 32'h0000_0000;
            if (idx == `IDX_DISC_BW)
                prdata[7:0] <= discriminator_bandwidth;
            else if (idx == `IDX_POST_FILT)
                prdata[7:0] <= post_filter_bandwidth_code;
            else if (idx == `IDX_DISC_PHASE)
                prdata[1:0] <= discriminator_phase;
            else if (idx == `IDX_IF_BW)
                prdata[7:0] <= if_cfg;
            else if (idx == `IDX_FC_MODE)
                prdata[7:0] <= mode_cfg;
            else if (idx == `IDX_LOOP_GAIN)
                prdata[7:0] <= gain_cfg;
            else if (idx == `IDX_PRE_DET)
                prdata[7:0] <= pre_cfg;
            else if (idx == `IDX_FREQ_ERR)
                prdata[7:0] <= freq_err;
            else if (idx == `IDX_RX_STATUS)
                prdata[2:0] <= {bit_synced, err_valid, loop_locked};
            else
                pslverr <= 1'b1;
        end
    end
end
// ====================================================================
// register writes
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        discriminator_bandwidth    <= `RST_DISC_BW;
        post_filter_bandwidth_code <= `RST_POST_FILT;
        discriminator_phase        <= 2'h0;
        if_cfg   <= `RST_IF_BW;
        mode_cfg <= `RST_FC_MODE;
        gain_cfg <= `RST_LOOP_GAIN;
        pre_cfg  <= `RST_PRE_DET;
    end else if (wr_acc) begin
        // host computes these values, hardware only stores them
        if (idx == `IDX_DISC_BW)
            discriminator_bandwidth <= pwdata[7:0];
        else if (idx == `IDX_POST_FILT)
            post_filter_bandwidth_code <= pwdata[7:0];
        else if (idx == `IDX_DISC_PHASE)
            discriminator_phase <= pwdata[1:0];
        else if (idx == `IDX_IF_BW)
            if_cfg <= pwdata[7:0];
        else if (idx == `IDX_FC_MODE)
            mode_cfg <= pwdata[7:0];
        else if (idx == `IDX_LOOP_GAIN)
            gain_cfg <= pwdata[7:0];
        else if (idx == `IDX_PRE_DET)
            pre_cfg <= pwdata[7:0];
    end
end
// ====================================================================
// pull-in limit from if bandwidth
reg  [7:0] pull_in;
always @* begin
    case (if_bandwidth)
        2'h0: pull_in = `PULL_100;
        2'h1: pull_in = `PULL_150;
        2'h2: pull_in = `PULL_200;
        default: pull_in = `PULL_300;
    endcase
end
// ====================================================================
// lock state machine
localparam ST_TRACK = 2'h0;
localparam ST_PRE   = 2'h1;
localparam ST_LOCK  = 2'h2;
reg  [1:0] state;
reg  [1:0] next_state;
wire       mode_lock = (freq_control_mode == `FC_LOCK);
wire       release_stream = ~packet_mode &
                            (idle_on_state | receive_command);
always @* begin
    next_state = state;
    case (state)
        ST_TRACK: begin
            if (mode_lock & receive_state & pre_en & preamble_found)
                next_state = ST_PRE;
            else if (mode_lock & receive_state & ~pre_en & sync_found)
                next_state = ST_LOCK;
        end
        ST_PRE: begin
            if (sync_found)
                next_state = ST_LOCK;
            else if (sync_window_over)
                next_state = ST_TRACK;
        end
        ST_LOCK: begin
            if (packet_mode & packet_end)
                next_state = ST_TRACK;
            else if (release_stream)
                next_state = ST_TRACK;
        end
        default: next_state = ST_TRACK;
    endcase
    if (~mode_lock)
        next_state = ST_TRACK;
    if (state == ST_PRE && release_stream)
        next_state = ST_TRACK;
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state       <= ST_TRACK;
        loop_locked <= 1'b0;
    end else begin
        state       <= next_state;
        loop_locked <= (next_state != ST_TRACK);
    end
end
// ====================================================================
// pi loop, saturated to the pull-in range
wire        loop_run = receive_state & fsk_on & (state == ST_TRACK) &
                       ((freq_control_mode == `FC_FREE) | mode_lock);
reg  signed [15:0] integ;
wire signed [15:0] err16 = {{8{freq_error_khz[7]}}, freq_error_khz};
wire signed [15:0] p_term = err16 >>> loop_proportional_gain;
wire signed [15:0] i_next = integ + (err16 >>> loop_integral_gain);
wire signed [15:0] lim = {8'h00, pull_in};
wire signed [15:0] i_sat = (i_next > lim) ? lim :
                           (i_next < -lim) ? -lim : i_next;
wire signed [15:0] sum = i_sat + p_term;
wire signed [15:0] sum_sat = (sum > lim) ? lim :
                             (sum < -lim) ? -lim : sum;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        integ         <= 16'h0000;
        lo_correction <= 8'h00;
        freq_err      <= 8'h00;
        err_valid     <= 1'b0;
    end else begin
        if (freq_control_mode == `FC_OFF) begin
            integ         <= 16'h0000;
            lo_correction <= 8'h00;
        end else if (loop_run) begin
            integ         <= i_sat;
            lo_correction <= sum_sat[7:0];
        end
        // hold mode and lock states keep the correction frozen
        if (freq_control_mode != `FC_OFF && receive_state &&
                next_state != ST_TRACK && state == ST_TRACK) begin
            freq_err  <= freq_error_khz;
            err_valid <= 1'b1;
        end
        if (freq_control_mode != `FC_OFF && loop_run)
            freq_err <= freq_error_khz;
    end
end
// ====================================================================
// post filter: two cascaded one-pole sections
// coefficient is a power of two picked from code ranges; coarse, not an exact corner
reg  signed [15:0] stage1;
reg  signed [15:0] stage2;
wire signed [15:0] x16 = {disc_sample, 8'h00};
wire [3:0]  shift = (post_filter_bandwidth_code > 8'h3F) ? 4'h1 :
                    (post_filter_bandwidth_code > 8'h0F) ? 4'h2 :
                    (post_filter_bandwidth_code > 8'h03) ? 4'h3 : 4'h4;
reg  [3:0]  sdiv_cnt;
wire        sample_en = (sdiv_cnt == 4'h0);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stage1   <= 16'h0000;
        stage2   <= 16'h0000;
        sdiv_cnt <= 4'h0;
    end else begin
        sdiv_cnt <= (sdiv_cnt == SDIV[3:0] - 4'h1) ? 4'h0
                                                   : sdiv_cnt + 4'h1;
        if (sample_en) begin
            stage1 <= stage1 + ((x16 - stage1) >>> shift);
            stage2 <= stage2 + ((stage1 - stage2) >>> shift);
        end
    end
end
// ====================================================================
// clock and data recovery
wire cdr_valid;
wire cdr_bit;
wire cdr_sync;
cdr_loop #(
    .OSR        (OSR)
) u_cdr (
    .pclk       (pclk),
    .presetn    (presetn),
    .sample_en  (sample_en),
    .sample_bit (~stage2[15]),
    .bit_valid  (cdr_valid),
    .bit_out    (cdr_bit),
    .synced     (cdr_sync)
);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        data_valid <= 1'b0;
        data_bit   <= 1'b0;
        bit_synced <= 1'b0;
    end else begin
        data_valid <= cdr_valid;
        data_bit   <= cdr_bit;
        bit_synced <= cdr_sync;
    end
end
endmodule // fsk_rx_afc_cdr_control
`default_nettype wire

//--- test/fsk_rx_afc_cdr_control_props.sv
// Purpose: port checks for the receive control block
// Assumes: one pclk domain, async active low reset
// Notes:   lock config mirrored from completed apb writes
`timescale 1ns/1ps
`default_nettype none
`include "fsk_rx_defs.vh"
module fsk_rx_afc_cdr_control_props (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // receive context
    input wire logic        receive_state,
    input wire logic        idle_on_state,
    input wire logic        receive_command,
    input wire logic        packet_mode,
    input wire logic        preamble_found,
    input wire logic        sync_found,
    input wire logic        sync_window_over,
    input wire logic        packet_end,
    // status
    input wire logic        loop_locked,
    input wire logic        bit_synced
);
    // ==================================================================
    // mirror
    logic [1:0] mode;
    logic       pre_en;
    logic       quiet;
    assign quiet = !preamble_found && !sync_found;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode   <= 2'h0;
            pre_en <= 1'h1;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == {`IDX_FC_MODE, 2'h0})
                mode <= pwdata[1:0];
            if (paddr == {`IDX_PRE_DET, 2'h0})
                pre_en <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_pready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_mode_no_lock: assert property (mode != 2'h3 && !loop_locked |=> !loop_locked)
        else $error("lock outside lock mode");
    chk_lock_on_preamble: assert property (mode == 2'h3 && pre_en && receive_state && preamble_found |=> loop_locked)
        else $error("no lock on preamble");
    chk_release_no_sync: assert property (sync_window_over && quiet |=> !loop_locked)
        else $error("lock kept without sync");
    chk_packet_end_release: assert property (packet_mode && packet_end && quiet |=> !loop_locked)
        else $error("lock kept after packet");
    chk_stream_release: assert property (!packet_mode && (idle_on_state || receive_command) && quiet |=> !loop_locked)
        else $error("stream lock not released");
    chk_lock_on_sync: assert property (mode == 2'h3 && !pre_en && receive_state && sync_found |=> loop_locked)
        else $error("no lock on sync");
    cover property ($rose(loop_locked));
    cover property (pslverr);
    cover property ($rose(bit_synced));
endmodule // fsk_rx_afc_cdr_control_props
bind fsk_rx_afc_cdr_control fsk_rx_afc_cdr_control_props props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_state(receive_state),
    .idle_on_state(idle_on_state), .receive_command(receive_command),
    .packet_mode(packet_mode), .preamble_found(preamble_found),
    .sync_found(sync_found), .sync_window_over(sync_window_over),
    .packet_end(packet_end), .loop_locked(loop_locked),
    .bit_synced(bit_synced));
`default_nettype wire

//--- test/rf_front_model.sv
// Purpose: discriminator stream from the radio front end
// Assumes: nominal bit is 32 pclk cycles
// Notes:   bit length alternates 32/31, about 1.6 percent fast
`timescale 1ns/1ps
`default_nettype none
module rf_front_model #(
    parameter int PERIOD = 32
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // control
    input  wire logic             run,
    // stream
    output var  logic signed [7:0] disc_sample
);
    // ==================================================================
    // alternating preamble
    int   cnt;
    logic sym;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || !run) begin
            cnt         <= 0;
            sym         <= 1'b0;
            disc_sample <= 8'sh00;
        end else begin
            cnt <= (cnt >= PERIOD - 1 - sym) ? 0 : cnt + 1;
            if (cnt >= PERIOD - 1 - sym)
                sym <= !sym;
            disc_sample <= sym ? 8'sh40 : 8'shC0;
        end
    end
endmodule // rf_front_model
`default_nettype wire

//--- test/fsk_rx_afc_cdr_control_tb.sv
// Purpose: register, lock and recovery tests for the receive block
// Assumes: apb answer within one wait-free access
// Notes:   host-side settings computed here from the link figures
`timescale 1ns/1ps
`default_nettype none
`include "fsk_rx_defs.vh"
module fsk_rx_afc_cdr_control_tb;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              er, rx_st, idle_st, pkt, run, b;
    logic [4:0]        ev;
    logic signed [7:0] disc, ferr, lo;
    logic              locked, dv, dbit, synced;
    logic [7:0]        disc_bw;
    logic [1:0]        disc_ph;
    int                err_total, checked, n, k, bw, ph;
    logic [11:0] idx [7] = '{`IDX_DISC_BW, `IDX_POST_FILT, `IDX_DISC_PHASE,
        `IDX_IF_BW, `IDX_FC_MODE, `IDX_LOOP_GAIN, `IDX_PRE_DET};
    logic [7:0]  rst [7] = '{`RST_DISC_BW, `RST_POST_FILT, `RST_DISC_PHASE,
        `RST_IF_BW, `RST_FC_MODE, `RST_LOOP_GAIN, `RST_PRE_DET};
    int cfg [4][4] = '{'{50000, 100000, 200000, 25000},
        '{25000, 100000, 300000, 0}, '{50000, 50000, 200000, 0},
        '{60000, 60000, 300000, 0}};
    fsk_rx_afc_cdr_control #(.OSR(8), .SDIV(4)) fsk_rx_afc_cdr_control_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receive_state(rx_st),
        .idle_on_state(idle_st), .receive_command(ev[4]),
        .packet_mode(pkt), .preamble_found(ev[3]), .sync_found(ev[2]),
        .sync_window_over(ev[1]), .packet_end(ev[0]), .disc_sample(disc),
        .freq_error_khz(ferr), .lo_correction(lo), .loop_locked(locked),
        .data_valid(dv), .data_bit(dbit), .bit_synced(synced),
        .discriminator_bandwidth(disc_bw), .discriminator_phase(disc_ph));
    rf_front_model rf_front_model_inst (.pclk(pclk), .presetn(presetn),
        .run(run), .disc_sample(disc));
    // ==================================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] i, input int d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 2'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rc(input string nm, input logic [11:0] i, input int e);
        apb(1'b0, i, 0);
        chk(nm, e, rd);
    endtask
    task automatic pulse(input int j);
        @(posedge pclk);
        ev[j] <= 1'b1;
        @(posedge pclk);
        ev <= 5'h00;
        @(posedge pclk);
    endtask
    task automatic next_bit;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (dv !== 1'b1 && n < 100);
    endtask
    task automatic results;
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==================================================================
    // clock, watchdog, tests
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        results();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_st, idle_st, pkt, run, ev, ferr} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idx[j]) rc("reset value", idx[j], rst[j]);
        foreach (idx[j]) begin
            apb(1'b1, idx[j], 8'hA5);
            rc("read back", idx[j],
                (idx[j] == `IDX_DISC_PHASE) ? 8'h01 : 8'hA5);
        end
        apb(1'b0, 12'h200, 0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        foreach (cfg[j]) begin
            k = (2 * cfg[j][0] >= cfg[j][1]) ? cfg[j][2] / (cfg[j][0] + cfg[j][3]) : cfg[j][2] / cfg[j][1];
            bw = (k * 6500000 + cfg[j][2]) / (2 * cfg[j][2]);
            ph = k % 2 ? ((k + 1) / 2 % 2 ? 3 : 1) : (k / 2 % 2 ? 0 : 2);
            apb(1'b1, `IDX_DISC_BW, bw);
            apb(1'b1, `IDX_DISC_PHASE, ph);
            @(posedge pclk);
            chk("disc bw", bw, disc_bw);
            chk("disc phase", ph, disc_ph);
        end
        rx_st <= 1'b1;
        ferr <= 8'sh9C;
        apb(1'b1, `IDX_FC_MODE, 0);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, `IDX_IF_BW, j << 6);
            repeat (2000) @(posedge pclk);
            chk("pull in", j ? 75 : 50, lo[7] ? -lo : lo);
        end
        rc("freq error", `IDX_FREQ_ERR, 8'h9C);
        apb(1'b1, `IDX_FC_MODE, 3);
        apb(1'b1, `IDX_PRE_DET, 1);
        ferr <= 8'shFB;
        repeat (50) @(posedge pclk);
        pulse(3);
        chk("preamble lock", 1, locked);
        ferr <= 8'sh07;
        rc("latched error", `IDX_FREQ_ERR, 8'hFB);
        pulse(1);
        chk("no sync", 0, locked);
        pkt <= 1'b1;
        repeat (50) @(posedge pclk);
        pulse(3);
        pulse(2);
        repeat (100) @(posedge pclk);
        chk("packet hold", 1, locked);
        pulse(0);
        chk("packet end", 0, locked);
        {rx_st, idle_st} <= 2'b01;
        ferr <= 8'sh11;
        repeat (50) @(posedge pclk);
        rc("kept error", `IDX_FREQ_ERR, 8'h07);
        {rx_st, idle_st, pkt} <= 3'b100;
        apb(1'b1, `IDX_PRE_DET, 0);
        pulse(2);
        chk("sync lock", 1, locked);
        pulse(4);
        chk("rx command", 0, locked);
        pulse(2);
        idle_st <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("idle release", 0, locked);
        idle_st <= 1'b0;
        apb(1'b1, `IDX_PRE_DET, 1);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, `IDX_FC_MODE, m);
            pulse(3);
            chk("mode no lock", 0, locked);
        end
        apb(1'b1, `IDX_POST_FILT, 8'h75);
        run <= 1'b1;
        n = 0;
        while (synced !== 1'b1 && n < 384) begin
            @(posedge pclk);
            n++;
        end
        chk("bit sync", 1, synced);
        next_bit();
        b = dbit;
        repeat (6) begin
            next_bit();
            chk("alternate bit", !b, dbit);
            b = dbit;
        end
        results();
    end
endmodule // fsk_rx_afc_cdr_control_tb
`default_nettype wire
